// ==== pkg/edge_timer_pkg.sv ====
package edge_timer_pkg;
    // register byte addresses (one aligned word each)
    localparam logic [7:0] ctrl0_addr = 8'h00;
    localparam logic [7:0] ctrl1_addr = 8'h04;
    localparam logic [7:0] count_low_addr = 8'h08;
    localparam logic [7:0] count_high_addr = 8'h0C;
    localparam logic [7:0] cmp_low_addr = 8'h10;
    localparam logic [7:0] cmp_high_addr = 8'h14;
    localparam logic [7:0] cap_low_addr = 8'h18;
    localparam logic [7:0] cap_high_addr = 8'h1C;
    localparam logic [7:0] flags_addr = 8'h20;
    localparam int addr_w = 8;
    // control 0 field positions
    localparam int clk_sel_lsb = 4;
    localparam int module_on_bit = 3;
    localparam int src_sel_lsb = 0;
    // control 1 field positions
    localparam int edge_sel_lsb = 6;
    localparam int trig_en_bit = 5;
    localparam int filt_cnt_bit = 4;
    localparam int filt_clk_bit = 3;
    localparam int filt_en_bit = 2;
    localparam int clr_trig_bit = 1;
    localparam int clr_match_bit = 0;
    // flag register bits, write one to clear
    localparam int ovf_bit = 0;
    localparam int match_bit = 1;
    // reset values and the control 0 write mask
    localparam logic [7:0] ctrl_reset = 8'h00;
    localparam logic [7:0] ctrl0_mask = 8'h7B;
    localparam logic [15:0] count_reset = 16'h0000;
    // edge selection codes
    localparam logic [1:0] edge_off = 2'h0;
    localparam logic [1:0] edge_rise = 2'h1;
    localparam logic [1:0] edge_fall = 2'h2;
    localparam logic [1:0] edge_both = 2'h3;
    // count clock code for the pwm tick
    localparam logic [2:0] clk_pwm = 3'h0;
    // filter: samples needed and slow sample divide
    localparam int filt_short = 2;
    localparam int filt_long = 4;
    localparam int filt_div = 4;
    localparam logic [1:0] axi_okay = 2'h0;
    localparam logic [1:0] axi_slverr = 2'h2;
endpackage

// ==== design/edge_filter.sv ====
// glitch filter: edge passes once level held n samples
module edge_filter
    import edge_timer_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic enable,
    input wire logic slow_clk,
    input wire logic long_cnt,
    input wire logic din,
    output logic dout
);
    logic [1:0] div_ff;
    logic [2:0] hist_ff;
    logic stable_ff;
    wire sample = !slow_clk || (div_ff == 2'(filt_div - 1));
    wire all_hi = long_cnt ? (&hist_ff && din) : (hist_ff[0] && din);
    wire all_lo = long_cnt ? (~|hist_ff && !din) : (!hist_ff[0] && !din);
    // sample divider and history shift
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_ff <= 2'h0;
            hist_ff <= 3'h0;
            stable_ff <= 1'b0;
        end else begin
            div_ff <= div_ff + 2'h1;
            if (sample) begin
                hist_ff <= {hist_ff[1:0], din};
                if (all_hi)
                    stable_ff <= 1'b1; // RQ7
                else if (all_lo)
                    stable_ff <= 1'b0; // RQ7
            end
        end
    end
    assign dout = enable ? stable_ff : din;
    chk_filter_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        enable && $rose(stable_ff) |-> $past(din)) // RQ7
        else $error("filter rose without high sample");
endmodule

// ==== design/edge_timer.sv ====
// How it works
// [RQ1] 16-bit compare value in low/high byte registers, reset to zero.
// [RQ2] 16-bit capture value in two read-only bytes, undefined until captured.
// [RQ3] four capture sources; only the selected one triggers captures.
// [RQ4] capture on rising, falling or both edges by two-bit field.
// [RQ5] module enable off stops counter and idles the timer.
// [RQ6] separate capture input enable gates triggering.
// [RQ7] glitch filter needs 2 or 4 equal samples at fsys or fsys/4.
// [RQ8] valid trigger copies the counter into the capture pair.
// [RQ9] counter overflow sets the overflow flag.
// [RQ10] clear-after-trigger zeroes counter after capture, counting continues.
// [RQ11] counter equal to compare value sets the match flag.
// [RQ12] clear-after-match zeroes counter on compare match.
// [RQ13] count clock: code 0 pwm tick, else fsys divided 2 to 128.
// [RQ14] source codes: 0 hall a, 1 hall b, 2 hall c, 3 pin.
// [RQ15] edge codes: 0 off, 1 rising, 2 falling, 3 both.
// [RQ16] enable rising zeroes counter; falling keeps residual count.
// [RQ17] counter wraps from max to zero and keeps counting.
// [RQ18] flags stay set until software clears; set wins over clear.
//
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
module edge_timer
    import edge_timer_pkg::*;
#(
    parameter int count_w = 16
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [edge_timer_pkg::addr_w-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [edge_timer_pkg::addr_w-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic hall_input_a,
    input wire logic hall_input_b,
    input wire logic hall_input_c,
    input wire logic external_trigger_pin,
    input wire logic pwm_period_tick,
    output logic overflow_flag,
    output logic match_flag
);
    import edge_timer_pkg::*;

    logic [7:0] ctrl0_ff, ctrl1_ff;
    logic [count_w-1:0] cmp_ff, cap_ff, cnt_ff;
    logic [6:0] pre_ff;
    logic on_d_ff, trig_d_ff, ovf_ff, match_ff;
    logic [addr_w-1:0] awaddr_ff;
    logic aw_held_ff, w_held_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;

    // control field decode
    wire [2:0] count_clock_select = ctrl0_ff[clk_sel_lsb +: 3];
    wire module_on = ctrl0_ff[module_on_bit];
    wire [1:0] trigger_source_select = ctrl0_ff[src_sel_lsb +: 2];
    wire [1:0] edge_select = ctrl1_ff[edge_sel_lsb +: 2];
    wire edge_select_hi = edge_select[1];
    wire edge_select_lo = edge_select[0];
    wire trigger_input_enable = ctrl1_ff[trig_en_bit];
    wire filter_sample_count_select = ctrl1_ff[filt_cnt_bit];
    wire filter_sample_clock_select = ctrl1_ff[filt_clk_bit];
    wire glitch_filter_enable = ctrl1_ff[filt_en_bit];
    wire clear_after_trigger = ctrl1_ff[clr_trig_bit];
    wire clear_after_match = ctrl1_ff[clr_match_bit];

    // 16-bit views of the counter-width registers for byte access
    wire [15:0] cnt_word = 16'(cnt_ff);
    wire [15:0] cmp_word = 16'(cmp_ff);
    wire [15:0] cap_word = 16'(cap_ff);

    // source select and filter
    wire [3:0] src_vec = {external_trigger_pin, hall_input_c,
                          hall_input_b, hall_input_a};
    wire src_raw = src_vec[trigger_source_select]; // RQ3 RQ14
    wire trig_lvl;
    edge_filter u_filter (
        .aclk(aclk),
        .aresetn(aresetn),
        .enable(glitch_filter_enable && module_on), // RQ7
        .slow_clk(filter_sample_clock_select),
        .long_cnt(filter_sample_count_select),
        .din(src_raw),
        .dout(trig_lvl)
    );

    // edge detect and capture gating
    wire rise = trig_lvl && !trig_d_ff;
    wire fall = !trig_lvl && trig_d_ff;
    wire edge_hit = (edge_select_lo && rise)
                  || (edge_select_hi && fall); // RQ4 RQ15
    wire capture = module_on && trigger_input_enable
                 && edge_hit; // RQ6 RQ8

    // count tick: pwm tick or prescaler tap
    wire [7:0] pre_next = {1'b0, pre_ff} + 8'h01;
    wire div_tick = pre_next[count_clock_select - 3'h1]
                  && !pre_ff[count_clock_select - 3'h1];
    wire tick = (count_clock_select == clk_pwm)
              ? pwm_period_tick : div_tick; // RQ13
    wire at_max = &cnt_ff;
    wire cmp_hit = module_on && (cnt_ff == cmp_ff); // RQ11
    wire hit_new = cmp_hit && (tick || capture);
    wire ovf_evt = module_on && tick && at_max; // RQ9
    wire on_rise = module_on && !on_d_ff;

    // counter next value
    logic [count_w-1:0] nxt_cnt;
    always_comb begin
        nxt_cnt = cnt_ff;
        if (on_rise)
            nxt_cnt = '0; // RQ16
        else if (!module_on)
            nxt_cnt = cnt_ff; // RQ5 RQ16
        else if (capture && clear_after_trigger)
            nxt_cnt = '0; // RQ10
        else if (cmp_hit && clear_after_match && tick)
            nxt_cnt = '0; // RQ12
        else if (tick)
            nxt_cnt = cnt_ff + 1'b1; // RQ17
    end

    // counter, prescaler, enable and trigger delay registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_ff <= count_w'(count_reset);
            pre_ff <= 7'h00;
            on_d_ff <= 1'b0;
            trig_d_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            pre_ff <= module_on ? pre_next[6:0] : 7'h00; // RQ5
            on_d_ff <= module_on;
            trig_d_ff <= trig_lvl;
        end
    end
    // capture pair: content means nothing until the first capture
    always_ff @(posedge aclk) begin
        if (!aresetn)
            cap_ff <= '0; // RQ2
        else if (capture)
            cap_ff <= cnt_ff; // RQ2 RQ8
    end

    // axi write: hold address and data in either order
    wire aw_ok = aw_held_ff || s_axi_awvalid;
    wire w_ok = w_held_ff || s_axi_wvalid;
    wire do_write = aw_ok && w_ok && !s_axi_bvalid;
    wire [addr_w-1:0] wr_addr = aw_held_ff ? awaddr_ff : s_axi_awaddr;
    wire [31:0] wr_data = w_held_ff ? wdata_ff : s_axi_wdata;
    wire [3:0] wr_strb = w_held_ff ? wstrb_ff : s_axi_wstrb;
    wire wr_lane = wr_strb[0];
    wire [7:0] wr_byte = wr_data[7:0];
    wire wr_map = (wr_addr <= flags_addr) && (wr_addr[1:0] == 2'h0);
    wire wr_en = do_write && wr_lane;
    wire clr_ovf = wr_en && wr_addr == flags_addr && wr_byte[ovf_bit];
    wire clr_match = wr_en && wr_addr == flags_addr && wr_byte[match_bit];
    assign s_axi_awready = !aw_held_ff && !s_axi_bvalid;
    assign s_axi_wready = !w_held_ff && !s_axi_bvalid;

    // write channel state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            awaddr_ff <= '0;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= axi_okay;
        end else begin
            if (do_write) begin
                aw_held_ff <= 1'b0;
                w_held_ff <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_map ? axi_okay : axi_slverr;
            end else begin
                if (s_axi_awvalid && s_axi_awready) begin
                    aw_held_ff <= 1'b1;
                    awaddr_ff <= s_axi_awaddr;
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    w_held_ff <= 1'b1;
                    wdata_ff <= s_axi_wdata;
                    wstrb_ff <= s_axi_wstrb;
                end
                if (s_axi_bready)
                    s_axi_bvalid <= 1'b0;
            end
        end
    end

    // software registers and sticky flags
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl0_ff <= ctrl_reset;
            ctrl1_ff <= ctrl_reset;
            cmp_ff <= count_w'(count_reset); // RQ1
            ovf_ff <= 1'b0;
            match_ff <= 1'b0;
        end else begin
            if (wr_en && wr_addr == ctrl0_addr)
                ctrl0_ff <= wr_byte & ctrl0_mask;
            if (wr_en && wr_addr == ctrl1_addr)
                ctrl1_ff <= wr_byte;
            if (wr_en && wr_addr == cmp_low_addr)
                cmp_ff <= count_w'({cmp_word[15:8], wr_byte}); // RQ1
            if (wr_en && wr_addr == cmp_high_addr)
                cmp_ff <= count_w'({wr_byte, cmp_word[7:0]}); // RQ1
            ovf_ff <= ovf_evt || (ovf_ff && !clr_ovf); // RQ9 RQ18
            match_ff <= hit_new || (match_ff && !clr_match); // RQ11 RQ18
        end
    end
    assign overflow_flag = ovf_ff;
    assign match_flag = match_ff;

    // read mux
    logic [7:0] rd_byte;
    always_comb begin
        unique case (s_axi_araddr)
            ctrl0_addr: rd_byte = ctrl0_ff;
            ctrl1_addr: rd_byte = ctrl1_ff;
            count_low_addr: rd_byte = cnt_word[7:0];
            count_high_addr: rd_byte = cnt_word[15:8];
            cmp_low_addr: rd_byte = cmp_word[7:0];
            cmp_high_addr: rd_byte = cmp_word[15:8];
            cap_low_addr: rd_byte = cap_word[7:0];
            cap_high_addr: rd_byte = cap_word[15:8];
            flags_addr: rd_byte = {6'h00, match_ff, ovf_ff};
            default: rd_byte = 8'h00;
        endcase
    end
    wire rd_map = (s_axi_araddr <= flags_addr)
                && (s_axi_araddr[1:0] == 2'h0);
    assign s_axi_arready = !s_axi_rvalid;

    // read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= axi_okay;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_map ? rd_byte : 8'h00};
            s_axi_rresp <= rd_map ? axi_okay : axi_slverr;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // checks
    chk_capture_copy: assert property (@(posedge aclk) disable iff (!aresetn)
        capture |=> cap_ff == $past(cnt_ff)) // RQ8
        else $error("capture value not copied");
    chk_source_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        !trigger_input_enable |=> $stable(cap_ff)) // RQ6
        else $error("capture while input disabled");
    // two cycles off in a row
    sequence s_held_off;
        !module_on ##1 !module_on;
    endsequence
    chk_off_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        s_held_off |-> $stable(cnt_ff)) // RQ5
        else $error("counter moved while off");
    chk_on_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        on_rise |=> cnt_ff == count_reset) // RQ16
        else $error("counter not zeroed on enable");
    chk_ovf_set: assert property (@(posedge aclk) disable iff (!aresetn)
        ovf_evt |=> ovf_ff) // RQ9
        else $error("overflow flag missed");
    chk_match_set: assert property (@(posedge aclk) disable iff (!aresetn)
        hit_new |=> match_ff) // RQ11
        else $error("match flag missed");
    chk_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
        ovf_ff && !clr_ovf |=> ovf_ff) // RQ18
        else $error("overflow flag dropped");
    chk_trig_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        capture && clear_after_trigger && !on_rise |=> cnt_ff == '0) // RQ10
        else $error("counter not cleared after capture");
    chk_match_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        cmp_hit && tick && clear_after_match && !capture
        |=> cnt_ff == '0) // RQ12
        else $error("counter not cleared on match");
    chk_wrap_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        ovf_evt && !capture |=> cnt_ff == '0) // RQ17
        else $error("counter did not wrap");
    chk_edge_off: assert property (@(posedge aclk) disable iff (!aresetn)
        edge_select == edge_off |-> !capture) // RQ15
        else $error("capture with edges off");
endmodule

// ==== tb/hall_source.sv ====
// sensor side: hall lines and trigger pin, changed only after an edge
module hall_source (
    input wire logic aclk,
    input wire logic [3:0] want,
    output logic hall_a = 1'b0,
    output logic hall_b = 1'b0,
    output logic hall_c = 1'b0,
    output logic pin = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    // levels follow the bench request one edge later
    always @(posedge aclk) begin
        {pin, hall_c, hall_b, hall_a} <= want;
    end
endmodule

// ==== tb/testbench.sv ====
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import edge_timer_pkg::*;
    localparam int cw = 10;
    logic aclk, aresetn = 1'b0, pwm_period_tick = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'h0, want = 4'h0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, overflow_flag, match_flag;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs, bs;
    logic hall_input_a, hall_input_b, hall_input_c, external_trigger_pin;
    logic [15:0] exp_cap;
    int n_mismatch = 0, compares = 0, cyc = 0, cnt = 0;
    edge_timer #(.count_w(cw)) i_dut (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .hall_input_a, .hall_input_b, .hall_input_c, .external_trigger_pin,
        .pwm_period_tick, .overflow_flag, .match_flag);
    hall_source i_src (.aclk, .want, .hall_a(hall_input_a),
        .hall_b(hall_input_b), .hall_c(hall_input_c),
        .pin(external_trigger_pin));
    // 250 MHz clock
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    task automatic summarize;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // bus write: both channels offered, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic bh;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        bh = 1'b0;
        while (!bh) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            bh = s_axi_bvalid;
            bs = s_axi_bresp;
        end
        s_axi_bready <= 1'b0;
    endtask
    // bus read: data and response taken at the rvalid edge
    task automatic rdr(input logic [7:0] a);
        logic vh;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        vh = 1'b0;
        while (!vh) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            vh = s_axi_rvalid;
            rd = s_axi_rdata;
            rs = s_axi_rresp;
        end
        s_axi_rready <= 1'b0;
    endtask
    // one-cycle pwm pulses, counter model advances with them
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge aclk);
            pwm_period_tick <= 1'b1;
            @(posedge aclk);
            pwm_period_tick <= 1'b0;
        end
        repeat (3) @(posedge aclk);
        cnt = (cnt + n) % (1 << cw);
    endtask
    task automatic cap_chk;
        rdr(cap_low_addr);
        chk({26'h0, rd[7:0]}, {26'h0, exp_cap[7:0]});
        rdr(cap_high_addr);
        chk({26'h0, rd[7:0]}, {26'h0, exp_cap[15:8]});
    endtask
    task automatic cnt_chk;
        rdr(count_low_addr);
        chk({rs, rd}, {26'h0, 8'(cnt)});
        rdr(count_high_addr);
        chk({rs, rd}, {26'h0, 8'(cnt >> 8)});
    endtask
    // change one source line, then see whether a capture followed
    task automatic pin(input int l, input logic v, input logic c);
        @(posedge aclk);
        want[l] <= v;
        repeat (30) @(posedge aclk);
        if (c) exp_cap = 16'(cnt);
        cap_chk();
    endtask
    task automatic glitch(input int n);
        @(posedge aclk);
        want[0] <= 1'b1;
        repeat (n) @(posedge aclk);
        want[0] <= 1'b0;
        repeat (30) @(posedge aclk);
        cap_chk();
    endtask
    // counter zeroed by enabling the module
    task automatic restart(input logic [7:0] c0, input logic [7:0] c1);
        wr(ctrl0_addr, 8'h00);
        wr(ctrl1_addr, c1);
        wr(ctrl0_addr, c0);
        cnt = 0;
    endtask
    task automatic t_reset;
        logic [7:0] a[6] = '{ctrl0_addr, ctrl1_addr, cmp_low_addr,
            cmp_high_addr, flags_addr, count_high_addr};
        foreach (a[i]) begin
            rdr(a[i]);
            chk({rs, rd}, 34'h0);
        end
        wr(cmp_low_addr, 8'hA5);
        wr(cmp_high_addr, 8'h03);
        chk({32'h0, bs}, {32'h0, axi_okay});
        wr(count_low_addr, 8'h5A);
        wr(8'h24, 8'h00);
        chk({32'h0, bs}, {32'h0, axi_slverr});
        rdr(cmp_low_addr);
        chk({rs, rd}, 34'h0A5);
        rdr(cmp_high_addr);
        chk({rs, rd}, 34'h003);
        cnt_chk();
        rdr(8'h24);
        chk({rs, rd}, {axi_slverr, 32'h0});
    endtask
    task automatic t_sources;
        for (int s = 0; s < 4; s++) begin
            restart({5'h01, 1'b0, 2'(s)}, 8'h60);
            ticks(s + 2);
            pin(s, 1'b1, 1'b1);
            ticks(1);
            pin((s + 1) % 4, 1'b1, 1'b0);
            pin((s + 1) % 4, 1'b0, 1'b0);
            pin(s, 1'b0, 1'b0);
        end
    endtask
    task automatic t_edges;
        restart(8'h08, 8'hA0);
        ticks(1);
        pin(0, 1'b1, 1'b0);
        ticks(1);
        pin(0, 1'b0, 1'b1);
        wr(ctrl1_addr, 8'hE0);
        ticks(1);
        pin(0, 1'b1, 1'b1);
        ticks(1);
        pin(0, 1'b0, 1'b1);
        wr(ctrl1_addr, 8'h20);
        ticks(1);
        pin(0, 1'b1, 1'b0);
        pin(0, 1'b0, 1'b0);
    endtask
    task automatic t_gate;
        restart(8'h08, 8'h40);
        ticks(2);
        pin(0, 1'b1, 1'b0);
        pin(0, 1'b0, 1'b0);
        wr(ctrl1_addr, 8'h62);
        ticks(4);
        pin(0, 1'b1, 1'b1);
        cnt = 0;
        cnt_chk();
        ticks(2);
        cnt_chk();
        pin(0, 1'b0, 1'b0);
    endtask
    task automatic t_filter;
        restart(8'h08, 8'h64);
        ticks(3);
        glitch(1);
        pin(0, 1'b1, 1'b1);
        pin(0, 1'b0, 1'b0);
        wr(ctrl1_addr, 8'h7C);
        ticks(1);
        glitch(6);
        pin(0, 1'b1, 1'b1);
    endtask
    task automatic t_match;
        restart(8'h08, 8'h01);
        wr(cmp_low_addr, 8'h05);
        wr(cmp_high_addr, 8'h00);
        ticks(4);
        chk({33'h0, match_flag}, 34'h0);
        ticks(2);
        chk({33'h0, match_flag}, 34'h1);
        rdr(count_low_addr);
        chk({33'h0, rd < 2}, 34'h1);
        ticks(10);
        chk({33'h0, match_flag}, 34'h1);
        wr(flags_addr, 8'h02);
        chk({33'h0, match_flag}, 34'h0);
    endtask
    task automatic t_wrap;
        int k;
        restart(8'h08, 8'h00);
        wr(cmp_high_addr, 8'hF0);
        ticks(3);
        chk({33'h0, overflow_flag}, 34'h0);
        ticks((1 << cw) - 3);
        chk({33'h0, overflow_flag}, 34'h1);
        cnt_chk();
        ticks(5);
        cnt_chk();
        wr(ctrl0_addr, 8'h00);
        k = cnt;
        ticks(3);
        cnt = k;
        cnt_chk();
        wr(ctrl0_addr, 8'h08);
        cnt = 0;
        cnt_chk();
        wr(flags_addr, 8'h03);
        chk({33'h0, overflow_flag}, 34'h0);
    endtask
    task automatic t_div;
        for (int k = 1; k < 8; k++) begin
            restart({1'b0, 3'(k), 4'h8}, 8'h00);
            repeat ((1 << k) * 8) @(posedge aclk);
            rdr(count_low_addr);
            chk({33'h0, rd >= 8 && rd <= 9 + (8 >> k)}, 34'h1);
        end
    endtask
    // hang guard
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_mismatch++;
            summarize();
        end
    end
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_sources();
        t_edges();
        t_gate();
        t_filter();
        t_match();
        t_wrap();
        t_div();
        summarize();
    end
endmodule
